// File: include/ptt_pkg.sv
// package: constants and carrier types of the periodic tick timer
package ptt_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_MODULUS = 10'h000;
  localparam logic [9:0] IDX_CTRL = 10'h002;
  localparam logic [9:0] IDX_COUNT = 10'h006;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h008;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h009;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h00a;
  localparam int ADDR_W = 12;
  // ----------------------------------------------------------------
  // control and status field positions
  // ----------------------------------------------------------------
  localparam int CS_EN = 0;
  localparam int CS_RLD = 1;
  localparam int CS_FLAG = 2;
  localparam int CS_IE = 3;
  localparam int CS_OVW = 4;
  localparam int CS_DBG = 5;
  localparam int CS_DOZE = 6;
  localparam int CS_PRE_LSB = 8;
  localparam int PRE_W = 4;
  localparam int IRQ_TIMEOUT = 0;
  // ----------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] MODULUS_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [15:0] WRAP_VALUE = 16'hffff;
  localparam logic [3:0] PRE_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } ptt_axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ptt_axil_rsp_t;
endpackage

// File: hdl/ptt_prescaler.sv
// prescaler: power-of-two divider producing count ticks
`timescale 1ns/1ps
`default_nettype none
module ptt_prescaler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic run,
  input wire logic [ptt_pkg::PRE_W-1:0] pre,
  output logic tick
);
  import ptt_pkg::*;
  logic [14:0] cnt_r;
  logic [14:0] limit;
  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  assign limit = 15'((16'h0001 << pre) - 16'h0001);
  // a clear restarts the division, so no tick leaks out of that cycle
  assign tick = run && !clear && (cnt_r == limit);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 15'h0000;
    end else if (clear) begin
      cnt_r <= 15'h0000;
    end else if (run) begin
      cnt_r <= tick ? 15'h0000 : cnt_r + 15'h0001;
    end
  end
  property p_clear_zero;
    @(posedge core_clk) disable iff (!nrst)
    clear |=> (cnt_r == 15'h0000) && !$past(tick);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("prescaler not cleared");
  property p_hold_idle;
    @(posedge core_clk) disable iff (!nrst)
    (!run && !clear) |=> $stable(cnt_r);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("prescaler moved while stopped");
endmodule
`default_nettype wire

// File: hdl/ptt_down_counter.sv
// down counter: 16-bit count with reload or wrap
`timescale 1ns/1ps
`default_nettype none
module ptt_down_counter (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic reload_en,
  input wire logic [15:0] modulus,
  output logic [15:0] count,
  output logic reach_zero
);
  import ptt_pkg::*;
  logic [15:0] count_r;
  assign count = count_r;
  // a pending immediate load wins over a tick in the same cycle
  assign reach_zero = tick && !load && (count_r == 16'h0001);
  // ----------------------------------------------------------------
  // count
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= COUNT_RST;
    end else if (load) begin
      count_r <= load_val;
    end else if (tick) begin
      if (count_r == 16'h0000) begin
        count_r <= reload_en ? modulus : WRAP_VALUE;
      end else begin
        count_r <= count_r - 16'h0001;
      end
    end
  end
  property p_wrap;
    @(posedge core_clk) disable iff (!nrst)
    (tick && !load && count_r == 16'h0000 && !reload_en)
      |=> count_r == WRAP_VALUE;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("free run did not wrap");
  property p_reload;
    @(posedge core_clk) disable iff (!nrst)
    (tick && !load && count_r == 16'h0000 && reload_en)
      |=> count_r == $past(modulus);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload from modulus missed");
endmodule
`default_nettype wire

// File: hdl/ptt_timer.sv
// top: periodic tick timer with its register slave and interrupt
`timescale 1ns/1ps
`default_nettype none
module ptt_timer (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic doze_mode,
  input wire logic debug_mode,
  input wire ptt_pkg::ptt_axil_req_t axil_req,
  output ptt_pkg::ptt_axil_rsp_t axil_rsp,
  output logic irq
);
  import ptt_pkg::*;
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] mode_in;
  logic [1:0] mode_s1_r;
  logic [1:0] mode_s2_r;
  logic doze_s;
  logic debug_s;
  logic [15:0] modulus_r;
  logic en_r;
  logic rld_r;
  logic flag_r;
  logic ie_r;
  logic ovw_r;
  logic dbg_r;
  logic doze_r;
  logic [PRE_W-1:0] pre_r;
  logic irq_sts_r;
  logic irq_ena_r;
  logic irq_r;
  logic irq_nxt;
  logic aw_rdy_r;
  logic aw_have_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_rdy_r;
  logic w_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic ar_rdy_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_fire;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic lo_strb;
  logic mod_wr;
  logic ctrl_wr;
  logic sts_clr_wr;
  logic ena_wr;
  logic wr_mapped;
  logic [15:0] mod_new;
  logic [15:0] ctrl_view;
  logic [15:0] ctrl_new;
  logic imm_load;
  logic pre_chg;
  logic presc_clear;
  logic run;
  logic tick;
  logic reach_zero;
  logic [15:0] count;
  logic flag_clr;
  logic [31:0] rd_mux;
  logic rd_mapped;

  // ----------------------------------------------------------------
  // byte lane merge
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // mode input synchronisers
  // ----------------------------------------------------------------
  assign mode_in = {debug_mode, doze_mode};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        mode_s1_r[i] <= 1'b0;
        mode_s2_r[i] <= 1'b0;
      end else begin
        mode_s1_r[i] <= mode_in[i];
        mode_s2_r[i] <= mode_s1_r[i];
      end
    end
  end
  assign doze_s = mode_s2_r[0];
  assign debug_s = mode_s2_r[1];

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  assign aw_fire = axil_req.awvalid && aw_rdy_r;
  assign w_fire = axil_req.wvalid && w_rdy_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_idx = aw_addr_r[ADDR_W-1:2];
  assign lo_strb = |w_strb_r[1:0];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_rdy_r <= 1'b0;
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_fire) begin
      aw_rdy_r <= 1'b0;
      aw_have_r <= 1'b1;
      aw_addr_r <= axil_req.awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end else if (!aw_have_r && !bvalid_r) begin
      aw_rdy_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      w_rdy_r <= 1'b0;
      w_have_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (w_fire) begin
      w_rdy_r <= 1'b0;
      w_have_r <= 1'b1;
      w_data_r <= axil_req.wdata;
      w_strb_r <= axil_req.wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end else if (!w_have_r && !bvalid_r) begin
      w_rdy_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign mod_wr = wr_fire && (wr_idx == IDX_MODULUS) && lo_strb;
  assign ctrl_wr = wr_fire && (wr_idx == IDX_CTRL) && lo_strb;
  assign sts_clr_wr = wr_fire && (wr_idx == IDX_IRQ_CLEAR) && w_strb_r[0];
  assign ena_wr = wr_fire && (wr_idx == IDX_IRQ_ENABLE) && w_strb_r[0];
  // count writes are accepted and dropped
  assign wr_mapped = (wr_idx == IDX_MODULUS) || (wr_idx == IDX_CTRL) ||
                     (wr_idx == IDX_COUNT) ||
                     (wr_idx == IDX_IRQ_STATUS) ||
                     (wr_idx == IDX_IRQ_ENABLE) ||
                     (wr_idx == IDX_IRQ_CLEAR);
  assign mod_new = merge16(modulus_r, w_data_r[15:0], w_strb_r[1:0]);
  assign ctrl_new = merge16(ctrl_view, w_data_r[15:0], w_strb_r[1:0]);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && axil_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // modulus latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      modulus_r <= MODULUS_RST;
    end else if (mod_wr) begin
      modulus_r <= mod_new;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
      rld_r <= 1'b0;
      ie_r <= 1'b0;
      ovw_r <= 1'b0;
      dbg_r <= 1'b0;
      doze_r <= 1'b0;
      pre_r <= PRE_RST;
    end else if (ctrl_wr) begin
      // enable and divider may land in one write
      en_r <= ctrl_new[CS_EN];
      rld_r <= ctrl_new[CS_RLD];
      ie_r <= ctrl_new[CS_IE];
      ovw_r <= ctrl_new[CS_OVW];
      dbg_r <= ctrl_new[CS_DBG];
      doze_r <= ctrl_new[CS_DOZE];
      pre_r <= ctrl_new[CS_PRE_LSB +: PRE_W];
    end
  end

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[CS_EN] = en_r;
    ctrl_view[CS_RLD] = rld_r;
    ctrl_view[CS_FLAG] = flag_r;
    ctrl_view[CS_IE] = ie_r;
    ctrl_view[CS_OVW] = ovw_r;
    ctrl_view[CS_DBG] = dbg_r;
    ctrl_view[CS_DOZE] = doze_r;
    ctrl_view[CS_PRE_LSB +: PRE_W] = pre_r;
  end

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  // wait mode is not an input: it never gates counting
  // stop mode gates the clock itself, nothing to do here
  assign run = en_r && !(doze_s && doze_r) &&
               !(debug_s && dbg_r);
  assign imm_load = mod_wr && ovw_r;
  assign pre_chg = ctrl_wr &&
                   (ctrl_new[CS_PRE_LSB +: PRE_W] != pre_r);
  // freezing holds the prescaler, disabling clears it
  assign presc_clear = imm_load || pre_chg || !en_r;

  ptt_prescaler u_presc (
    .core_clk(core_clk),
    .nrst(nrst),
    .clear(presc_clear),
    .run(run),
    .pre(pre_r),
    .tick(tick)
  );

  ptt_down_counter u_cnt (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(tick),
    .load(imm_load),
    .load_val(mod_new),
    .reload_en(rld_r),
    .modulus(modulus_r),
    .count(count),
    .reach_zero(reach_zero)
  );

  // ----------------------------------------------------------------
  // timeout flag and interrupt
  // ----------------------------------------------------------------
  assign flag_clr = mod_wr ||
                    (ctrl_wr && w_strb_r[0] && w_data_r[CS_FLAG]);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else if (reach_zero) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_sts_r <= 1'b0;
    end else if (reach_zero) begin
      irq_sts_r <= 1'b1;
    end else if (sts_clr_wr && w_data_r[IRQ_TIMEOUT]) begin
      irq_sts_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ena_r <= 1'b0;
    end else if (ena_wr) begin
      irq_ena_r <= w_data_r[IRQ_TIMEOUT];
    end
  end

  assign irq_nxt = (flag_r && ie_r) ||
                   (irq_sts_r && irq_ena_r);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign ar_fire = axil_req.arvalid && ar_rdy_r;
  assign rd_idx = axil_req.araddr[ADDR_W-1:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (rd_idx)
      IDX_MODULUS: rd_mux[15:0] = modulus_r;
      IDX_CTRL: rd_mux[15:0] = ctrl_view;
      // live value, upper and lower bytes sampled together
      IDX_COUNT: rd_mux[15:0] = count;
      IDX_IRQ_STATUS: rd_mux[IRQ_TIMEOUT] = irq_sts_r;
      IDX_IRQ_ENABLE: rd_mux[IRQ_TIMEOUT] = irq_ena_r;
      IDX_IRQ_CLEAR: rd_mux = 32'h0000_0000;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && axil_req.rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      ar_rdy_r <= 1'b1;
    end
  end

  always_comb begin
    axil_rsp.awready = aw_rdy_r;
    axil_rsp.wready = w_rdy_r;
    axil_rsp.bvalid = bvalid_r;
    axil_rsp.bresp = bresp_r;
    axil_rsp.arready = ar_rdy_r;
    axil_rsp.rvalid = rvalid_r;
    axil_rsp.rdata = rdata_r;
    axil_rsp.rresp = rresp_r;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_flag_set;
    reach_zero |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag missed at zero");

  property p_flag_write0;
    (ctrl_wr && !w_data_r[CS_FLAG] && !mod_wr && flag_r)
      |=> flag_r;
  endproperty
  a_flag_write0: assert property (p_flag_write0)
    else $error("writing zero cleared flag");

  property p_irq;
    (flag_r && ie_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  property p_disabled_hold;
    (!en_r && !imm_load) |=> $stable(count);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("counter moved while disabled");

  property p_debug_hold;
    (debug_s && dbg_r && !imm_load) |=> $stable(count);
  endproperty
  a_debug_hold: assert property (p_debug_hold)
    else $error("counter moved in debug freeze");

  property p_doze_hold;
    (doze_s && doze_r && !imm_load) |=> $stable(count);
  endproperty
  a_doze_hold: assert property (p_doze_hold)
    else $error("counter moved in doze freeze");

  property p_imm_load;
    imm_load |=> count == $past(mod_new);
  endproperty
  a_imm_load: assert property (p_imm_load)
    else $error("immediate load missed");

  property p_step;
    (tick && !imm_load && count != 16'h0000)
      |=> count == $past(count) - 16'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one");

  property p_mod_read;
    (ar_fire && rd_idx == IDX_MODULUS)
      |=> rvalid_r && rdata_r[15:0] == $past(modulus_r);
  endproperty
  a_mod_read: assert property (p_mod_read)
    else $error("modulus read wrong");

  property p_count_write;
    (wr_fire && wr_idx == IDX_COUNT)
      |=> bvalid_r && bresp_r == RESP_OKAY;
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("count write not answered okay");
endmodule
`default_nettype wire

// File: verification/tb.sv
// testbench: bus tasks, reference model and scenarios of the tick timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ptt_pkg::*;
  // ----------------------------------------------------------------
  // signals and reference model state
  // ----------------------------------------------------------------
  localparam logic [11:0] A_MOD = {IDX_MODULUS, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [11:0] A_STA = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_IEN = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [11:0] A_CLR = {IDX_IRQ_CLEAR, 2'b00};
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic doze_mode = 1'b0;
  logic debug_mode = 1'b0;
  ptt_axil_req_t req = '0;
  ptt_axil_rsp_t rsp;
  logic irq;
  int errors = 0;
  int n_tests = 0;
  int seed = 73;
  logic [15:0] mod_m = MODULUS_RST;
  logic [15:0] ctl_m = 16'h0000;
  logic [15:0] m;
  logic [15:0] fb;
  logic [31:0] rd;
  logic [1:0] rs;
  realtime rise_q[$];
  logic irq_q = 1'b0;

  always #12.5 core_clk = ~core_clk;

  ptt_timer u_ptt_timer (.core_clk(core_clk), .nrst(nrst),
    .doze_mode(doze_mode), .debug_mode(debug_mode),
    .axil_req(req), .axil_rsp(rsp), .irq(irq));

  // rise times feed the period model
  always @(posedge core_clk) begin
    irq_q <= irq;
    if (irq === 1'b1 && irq_q === 1'b0) rise_q.push_back($realtime);
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string w);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // entry edge keeps bready/rready from two drives in one step
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      n++;
    end while (rsp.bvalid !== 1'b1 && n < 200);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      n++;
    end while (rsp.rvalid !== 1'b1 && n < 200);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e,
                    input string w);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    chk(d, e, w);
    chk(r, RESP_OKAY, w);
  endtask

  // model keeps writable control bits; flag is write-one-clear
  task automatic wc(input logic [15:0] v);
    logic [1:0] r;
    wr(A_CTL, v, r);
    ctl_m = v & 16'h0f7b;
    chk(r, RESP_OKAY, "ctl wr");
  endtask

  task automatic wait_rise(input int n);
    int k;
    k = 0;
    while (rise_q.size() < n && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
    chk(rise_q.size() >= n, 1, "irq rise");
  endtask

  task automatic still(input logic e, input string w);
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0] r;
    rdr(A_CNT, a, r);
    cyc(6);
    rdr(A_CNT, b, r);
    chk(a === b, e, w);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #2500000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rc(A_MOD, 32'h0000ffff, "mod rst");
    rc(A_CTL, 0, "ctl rst");
    rc(A_CNT, 32'h0000ffff, "cnt rst");
    rc(A_STA, 0, "sta rst");
    rdr(12'h0fc, rd, rs);
    chk(rs, RESP_SLVERR, "unmapped rd");
    wr(12'h0fc, 16'h0001, rs);
    chk(rs, RESP_SLVERR, "unmapped wr");
    // low codes get random modulus, high codes a short one for run time
    for (int p = 0; p < 13; p++) begin
      m = (p < 3) ? 16'd10 + 16'($random(seed) & 15) : 16'd1;
      wc(16'h0010);
      wr(A_MOD, m, rs);
      mod_m = m;
      rc(A_CNT, 32'(m), "load");
      rc(A_MOD, 32'(m), "mod rd");
      rise_q.delete();
      wc(16'(16'h001b | (p << 8)));
      wait_rise(1);
      wc(ctl_m | 16'h0004);
      cyc(1);
      chk(irq, 0, "irq clr");
      wait_rise(2);
      rc(A_CTL, 32'(ctl_m | 16'h0004), "flag");
      chk(int'((rise_q[1] - rise_q[0]) / 25.0), (1 << p) * (m + 1),
          "period");
    end
    wc(16'h0010);
    wr(A_MOD, 16'h0003, rs);
    mod_m = 16'h0003;
    wr(A_CLR, 16'h0001, rs);
    wc(16'h0011);
    cyc(20);
    rdr(A_CNT, rd, rs);
    chk(rd[15:8], 8'hff, "wrap");
    chk(irq, 0, "masked");
    rc(A_STA, 1, "sticky");
    wr(A_IEN, 16'h0001, rs);
    cyc(1);
    chk(irq, 1, "sta irq");
    rc(A_IEN, 1, "ien");
    wr(A_CLR, 16'h0001, rs);
    cyc(1);
    chk(irq, 0, "sta irq clr");
    rc(A_STA, 0, "sta clr");
    rc(A_CLR, 0, "clr rd");
    wr(A_IEN, 16'h0000, rs);
    wc(16'h0008);
    cyc(1);
    chk(irq, 1, "flag irq");
    rc(A_CTL, 32'h000c, "w0 keeps");
    rdr(A_CNT, rd, rs);
    wr(A_MOD, 16'h0005, rs);
    mod_m = 16'h0005;
    rc(A_CNT, rd, "no load");
    rc(A_CTL, 32'h0008, "mod clr");
    wr(A_CNT, 16'h1234, rs);
    chk(rs, RESP_OKAY, "cnt wr");
    rc(A_CNT, rd, "cnt ro");
    // pins pass a two-flop synchroniser, hence the settle cycles
    wc(16'h0001);
    for (int i = 0; i < 2; i++) begin
      fb = (i == 0) ? 16'h0040 : 16'h0020;
      if (i == 0) begin
        doze_mode <= 1'b1;
      end else begin
        debug_mode <= 1'b1;
      end
      wc(16'h0001 | fb);
      cyc(4);
      still(1'b1, "frozen");
      rc(A_MOD, 32'(mod_m), "access");
      wc(16'h0001);
      still(1'b0, "unfrozen");
      wc(16'h0001 | fb);
      still(1'b1, "refrozen");
      doze_mode <= 1'b0;
      debug_mode <= 1'b0;
      cyc(4);
      still(1'b0, "resume");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
